// [hw/cpf_pkg.sv]
// Package with register map, field layout, format codes and types of the pixel formatter.
package cpf_pkg;

  localparam int          CPF_ADDR_W       = 12;
  localparam logic [11:0] CPF_OFS_VTC      = 12'h06C;
  localparam logic [11:0] CPF_OFS_SOFT_RESET_CMD   = 12'h07C;
  localparam logic [11:0] CPF_OFS_STREAM   = 12'h0C0;
  localparam logic [11:0] CPF_OFS_STATUS   = 12'h0C4;
  localparam logic [11:0] CPF_OFS_FMT      = 12'h0D4;
  localparam logic [11:0] CPF_OFS_CTL      = 12'h0D8;

  localparam int          CPF_HTRANS_ACT   = 1;

  localparam logic [7:0]  CPF_VTC_RST      = 8'h00;
  localparam logic [7:0]  CPF_VTC_MASK     = 8'h83;
  localparam int          CPF_VTC_WSEL     = 7;
  localparam logic [7:0]  CPF_FMT_RST      = 8'h00;
  localparam logic [7:0]  CPF_CTL_RST      = 8'h00;
  localparam logic [7:0]  CPF_STREAM_RST   = 8'h00;
  localparam logic [7:0]  CPF_STREAM_MASK  = 8'h0F;

  localparam int          CPF_CTL_STDSEL   = 7;
  localparam int          CPF_CTL_BARS     = 6;
  localparam int          CPF_CTL_DED      = 5;
  localparam int          CPF_CTL_GAMMA    = 4;
  localparam int          CPF_CTL_HSW_ODD  = 3;
  localparam int          CPF_CTL_HSW_EVEN = 2;
  localparam int          CPF_CTL_BSW_ODD  = 1;
  localparam int          CPF_CTL_BSW_EVEN = 0;

  localparam int          CPF_ST_CAP_EVEN  = 0;
  localparam int          CPF_ST_CAP_ODD   = 1;
  localparam int          CPF_ST_COMB      = 2;
  localparam int          CPF_ST_SPI16     = 3;

  localparam logic [6:0]  CPF_HRST_STD     = 7'd64;
  localparam logic [6:0]  CPF_HRST_NARROW  = 7'd32;

  typedef enum logic [3:0] {
    CPF_RGB32   = 4'h0,
    CPF_RGB24   = 4'h1,
    CPF_RGB16   = 4'h2,
    CPF_RGB15   = 4'h3,
    CPF_YUV422  = 4'h4,
    CPF_YUV411  = 4'h5,
    CPF_LUMA    = 4'h6,
    CPF_RGB8    = 4'h7,
    CPF_PLN422  = 4'h8,
    CPF_PLN411  = 4'h9,
    CPF_RAW8X   = 4'hE
  } cpf_fmt_type;

  typedef struct packed {
    logic [7:0] y;
    logic [7:0] cb;
    logic [7:0] cr;
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
    logic [7:0] raw;
  } cpf_pix_type;

  typedef struct packed {
    logic [2:0] taps;
    logic       interp;
  } cpf_vert_filter_taps_type;

  localparam logic [7:0]  CPF_BAR_LEVEL = 8'hBF;
  localparam logic [23:0] CPF_BAR_YCC [8] = '{24'hB48080, 24'hA22C8E, 24'h839C2C, 24'h70483A,
                                             24'h54B8C6, 24'h4164D4, 24'h23D472, 24'h108080};
  localparam logic [7:0]  CPF_ED_MASK16 [3] = '{8'h07, 8'h03, 8'h07};
  localparam logic [7:0]  CPF_ED_MASK15 [3] = '{8'h07, 8'h07, 8'h07};
  localparam logic [7:0]  CPF_ED_MASK8  [3] = '{8'h1F, 8'h1F, 8'h3F};

endpackage

// [hw/cpf_formatter.sv]
// Output pixel formatter: register slave, colour bars, gamma, diffusion, packing and swaps.
`timescale 1ns/1ps
module cpf_formatter
  import cpf_pkg::*;
#(
  parameter int BAR_WIDTH = 80
) (
  input  wire logic          ref_clk,
  input  wire logic          sys_rst,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic               hresp,
  output logic [31:0]        hrdata,
  input  wire cpf_pix_type   pix_in,
  input  wire logic          pix_valid,
  input  wire logic          line_start,
  input  wire logic          field_start,
  input  wire logic          field_even_in,
  input  wire logic          pal_mode,
  output logic               line_reset_pulse,
  output cpf_vert_filter_taps_type      vert_filter_taps_cfg,
  output logic               field_even,
  output logic               fifo_wr,
  output logic [31:0]        fifo_data
);

  // Bus slave. Every access completes without wait states and answers OKAY.
  logic             dp_wr_r;
  logic [11:0]      dp_addr_r;
  logic [31:0]      hrdata_r;
  logic [7:0]       vtc_r;
  logic [7:0]       fmt_r;
  logic [7:0]       ctl_r;
  logic [7:0]       stream_r;
  logic             field_even_r;
  logic [7:0]       words_r;

  wire              addr_ph   = hsel & hready & htrans[CPF_HTRANS_ACT];
  wire [11:0]       ap_addr   = haddr[11:0];
  wire              wr_vtc    = dp_wr_r & (dp_addr_r == CPF_OFS_VTC);
  wire              wr_fmt    = dp_wr_r & (dp_addr_r == CPF_OFS_FMT);
  wire              wr_ctl    = dp_wr_r & (dp_addr_r == CPF_OFS_CTL);
  wire              wr_stream = dp_wr_r & (dp_addr_r == CPF_OFS_STREAM);
  wire              soft_rst  = dp_wr_r & (dp_addr_r == CPF_OFS_SOFT_RESET_CMD);

  // Soft reset returns the VTC, format and control registers to reset values whatever the data; the stream register keeps its value.
  wire [7:0] vtc_nxt    = soft_rst ? CPF_VTC_RST :
                          wr_vtc ? (hwdata[7:0] & CPF_VTC_MASK) : vtc_r;
  wire [7:0] fmt_nxt    = soft_rst ? CPF_FMT_RST : wr_fmt ? hwdata[7:0] : fmt_r;
  wire [7:0] ctl_nxt    = soft_rst ? CPF_CTL_RST : wr_ctl ? hwdata[7:0] : ctl_r;
  wire [7:0] stream_nxt = wr_stream ? (hwdata[7:0] & CPF_STREAM_MASK) : stream_r;

  // Reads use the next values so a read right after a write sees the new data.
  wire [31:0] rd_val =
    (ap_addr == CPF_OFS_VTC)    ? {24'h000000, vtc_nxt} :
    (ap_addr == CPF_OFS_FMT)    ? {24'h000000, fmt_nxt} :
    (ap_addr == CPF_OFS_CTL)    ? {24'h000000, ctl_nxt} :
    (ap_addr == CPF_OFS_STREAM) ? {24'h000000, stream_nxt} :
    (ap_addr == CPF_OFS_STATUS) ? {16'h0000, words_r, 7'h00, field_even_r} :
    32'h00000000;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dp_wr_r   <= 1'b0;
      dp_addr_r <= 12'h000;
      hrdata_r  <= 32'h00000000;
    end else begin
      dp_wr_r <= addr_ph & hwrite;
      if (addr_ph) begin
        dp_addr_r <= ap_addr;
      end
      if (addr_ph & ~hwrite) begin
        hrdata_r <= rd_val;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      vtc_r    <= CPF_VTC_RST;
      fmt_r    <= CPF_FMT_RST;
      ctl_r    <= CPF_CTL_RST;
      stream_r <= CPF_STREAM_RST;
    end else begin
      vtc_r    <= vtc_nxt;
      fmt_r    <= fmt_nxt;
      ctl_r    <= ctl_nxt;
      stream_r <= stream_nxt;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  // Line reset pulse, counted from the clock after line_start.
  logic [6:0] hr_cnt_r;
  wire  [6:0] hr_width = vtc_r[CPF_VTC_WSEL] ? CPF_HRST_NARROW : CPF_HRST_STD;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hr_cnt_r <= 7'h00;
    end else if (line_start) begin
      hr_cnt_r <= hr_width;
    end else if (hr_cnt_r != 7'h00) begin
      hr_cnt_r <= hr_cnt_r - 7'h01;
    end
  end

  assign line_reset_pulse = (hr_cnt_r != 7'h00);

  // Vertical filter selection handed to the scaler.
  wire       luma_comb_enable = stream_r[CPF_ST_COMB];
  wire [1:0] vert_filter_taps = vtc_r[1:0];
  assign vert_filter_taps_cfg.taps   = luma_comb_enable ? ({1'b0, vert_filter_taps} + 3'h2) :
                            (vert_filter_taps == 2'h0) ? 3'h0 :
                            ({1'b0, vert_filter_taps} + 3'h1);
  assign vert_filter_taps_cfg.interp = ~luma_comb_enable;

  // Field parity: zero odd, one even.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      field_even_r <= 1'b0;
    end else if (field_start) begin
      field_even_r <= field_even_in;
    end
  end

  assign field_even = field_even_r;

  wire [3:0] fmt_code = field_even_r ? fmt_r[3:0] : fmt_r[7:4];
  wire       half_sw  = field_even_r ? ctl_r[CPF_CTL_HSW_EVEN] : ctl_r[CPF_CTL_HSW_ODD];
  wire       byte_sw  = field_even_r ? ctl_r[CPF_CTL_BSW_EVEN] : ctl_r[CPF_CTL_BSW_ODD];
  wire       cap_en   = field_even_r ? stream_r[CPF_ST_CAP_EVEN] : stream_r[CPF_ST_CAP_ODD];

  // Stage 1: colour bar source and gamma removal.
  logic [11:0] x_r;
  logic [11:0] bar_cnt_r;
  logic [2:0]  bar_idx_r;
  cpf_pix_type s1_r;
  logic        s1_v_r;
  logic [1:0]  s1_x_r;

  wire        bar_last = (bar_cnt_r == 12'(BAR_WIDTH - 1));
  wire [23:0] bar_ycc  = CPF_BAR_YCC[bar_idx_r];
  wire [2:0]  bar_rgb  = ~bar_idx_r;
  wire        bars_on  = ctl_r[CPF_CTL_BARS];
  wire        gamma_pal = stream_r[CPF_ST_SPI16] ? ctl_r[CPF_CTL_STDSEL] : pal_mode;
  wire        gamma_on  = ~ctl_r[CPF_CTL_GAMMA];

  cpf_pix_type src;
  assign src.y   = bars_on ? bar_ycc[23:16] : pix_in.y;
  assign src.cb  = bars_on ? bar_ycc[15:8]  : pix_in.cb;
  assign src.cr  = bars_on ? bar_ycc[7:0]   : pix_in.cr;
  assign src.r   = bars_on ? (bar_rgb[2] ? CPF_BAR_LEVEL : 8'h00) : pix_in.r;
  assign src.g   = bars_on ? (bar_rgb[1] ? CPF_BAR_LEVEL : 8'h00) : pix_in.g;
  assign src.b   = bars_on ? (bar_rgb[0] ? CPF_BAR_LEVEL : 8'h00) : pix_in.b;
  assign src.raw = pix_in.raw;

  // Power-law removal approximated by x^2 for 2.2 and x^3 for 2.8; this keeps the
  // table out of the design at the cost of a small error in the mid tones.
  function automatic logic [7:0] gamma_remove(input logic [7:0] v, input logic pal);
    logic [15:0] sq;
    logic [23:0] cu;
    sq = {8'h00, v} * {8'h00, v};
    cu = {8'h00, sq} * {16'h0000, v};
    gamma_remove = pal ? cu[23:16] : sq[15:8];
  endfunction

  always_ff @(posedge ref_clk) begin
    if (sys_rst | line_start) begin
      x_r       <= 12'h000;
      bar_cnt_r <= 12'h000;
      bar_idx_r <= 3'h0;
    end else if (pix_valid) begin
      x_r       <= x_r + 12'h001;
      bar_cnt_r <= bar_last ? 12'h000 : bar_cnt_r + 12'h001;
      bar_idx_r <= bar_last ? bar_idx_r + 3'h1 : bar_idx_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s1_r   <= '0;
      s1_v_r <= 1'b0;
      s1_x_r <= 2'h0;
    end else begin
      s1_v_r <= pix_valid;
      if (pix_valid) begin
        s1_r   <= src;
        s1_x_r <= x_r[1:0];
        if (gamma_on) begin
          s1_r.r <= gamma_remove(src.r, gamma_pal);
          s1_r.g <= gamma_remove(src.g, gamma_pal);
          s1_r.b <= gamma_remove(src.b, gamma_pal);
        end
      end
    end
  end

  // Stage 2: error diffusion per colour channel, carried along the line.
  wire fmt_rgb1615 = (fmt_code == CPF_RGB16) | (fmt_code == CPF_RGB15);
  wire ed_on = (fmt_rgb1615 & ~ctl_r[CPF_CTL_DED]) | (fmt_code == CPF_RGB8);
  wire [7:0] ch_in [3];
  logic [7:0] ch_out [3];
  logic [7:0] err_r [3];
  wire  act = s1_v_r & cap_en;

  assign ch_in[0] = s1_r.r;
  assign ch_in[1] = s1_r.g;
  assign ch_in[2] = s1_r.b;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_diff
      wire [8:0] sum  = {1'b0, ch_in[gi]} + {1'b0, err_r[gi]};
      wire [7:0] sat  = sum[8] ? 8'hFF : sum[7:0];
      wire [7:0] mask = (fmt_code == CPF_RGB8) ? CPF_ED_MASK8[gi] :
                        (fmt_code == CPF_RGB16) ? CPF_ED_MASK16[gi] : CPF_ED_MASK15[gi];
      assign ch_out[gi] = ed_on ? sat : ch_in[gi];
      always_ff @(posedge ref_clk) begin
        if (sys_rst | line_start) begin
          err_r[gi] <= 8'h00;
        end else if (act) begin
          err_r[gi] <= ed_on ? (sat & mask) : 8'h00;
        end
      end
    end
  endgenerate

  wire [7:0] pr = ch_out[0];
  wire [7:0] pg = ch_out[1];
  wire [7:0] pb = ch_out[2];

  // Bytes of the current pixel, lowest byte first, and how many of them.
  logic [31:0] pix_bytes;
  logic [2:0]  pix_nb;

  always_comb begin
    pix_bytes = 32'h00000000;
    pix_nb    = 3'h0;
    case (fmt_code)
      CPF_RGB32: begin
        pix_bytes = {8'h00, pr, pg, pb};
        pix_nb    = 3'h4;
      end
      CPF_RGB24: begin
        pix_bytes = {8'h00, pr, pg, pb};
        pix_nb    = 3'h3;
      end
      CPF_RGB16: begin
        pix_bytes = {16'h0000, pr[7:3], pg[7:2], pb[7:3]};
        pix_nb    = 3'h2;
      end
      CPF_RGB15: begin
        pix_bytes = {16'h0000, 1'b0, pr[7:3], pg[7:3], pb[7:3]};
        pix_nb    = 3'h2;
      end
      CPF_YUV422: begin
        pix_bytes = {16'h0000, (s1_x_r[0] ? s1_r.cr : s1_r.cb), s1_r.y};
        pix_nb    = 3'h2;
      end
      CPF_YUV411: begin
        pix_bytes = {16'h0000, (s1_x_r[1] ? s1_r.cr : s1_r.cb), s1_r.y};
        pix_nb    = s1_x_r[0] ? 3'h1 : 3'h2;
      end
      CPF_LUMA, CPF_PLN422, CPF_PLN411: begin
        // Planar modes carry only the luma plane here; their chroma samples are not output.
        pix_bytes = {24'h000000, s1_r.y};
        pix_nb    = 3'h1;
      end
      CPF_RGB8: begin
        pix_bytes = {24'h000000, pr[7:5], pg[7:5], pb[7:6]};
        pix_nb    = 3'h1;
      end
      CPF_RAW8X: begin
        pix_bytes = {24'h000000, s1_r.raw};
        pix_nb    = 3'h1;
      end
      default: begin
        pix_bytes = 32'h00000000;
        pix_nb    = 3'h0;
      end
    endcase
  end

  // Word packer: at most three bytes wait between pixels.
  logic [23:0] acc_r;
  logic [1:0]  acc_cnt_r;

  wire [55:0] ext   = {32'h00000000, acc_r} | ({24'h000000, pix_bytes} << {acc_cnt_r, 3'b000});
  wire [2:0]  total = {1'b0, acc_cnt_r} + pix_nb;
  wire        emit  = total[2];
  wire [31:0] w0    = ext[31:0];
  wire [31:0] w1    = half_sw ? {w0[15:0], w0[31:16]} : w0;
  wire [31:0] w2    = byte_sw ? {w1[23:16], w1[31:24], w1[7:0], w1[15:8]} : w1;

  logic        fifo_wr_r;
  logic [31:0] fifo_data_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst | field_start) begin
      acc_r     <= 24'h000000;
      acc_cnt_r <= 2'h0;
    end else if (act) begin
      acc_r     <= emit ? ext[55:32] : ext[23:0];
      acc_cnt_r <= total[1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fifo_wr_r   <= 1'b0;
      fifo_data_r <= 32'h00000000;
    end else begin
      fifo_wr_r <= act & emit;
      if (act & emit) begin
        fifo_data_r <= w2;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst | field_start) begin
      words_r <= 8'h00;
    end else if (fifo_wr_r) begin
      words_r <= words_r + 8'h01;
    end
  end

  assign fifo_wr   = fifo_wr_r;
  assign fifo_data = fifo_data_r;

endmodule

// [dv/cpf_fifo_sink.sv]
// Behavioural capture FIFO that takes every formatted word written by the pixel formatter.
`timescale 1ns/1ps
module cpf_fifo_sink (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        fifo_wr,
  input  wire logic [31:0] fifo_data,
  output int               word_cnt,
  output logic [31:0]      last_word
);
  // The far side never pushes back, so a write strobe always lands as one word.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      word_cnt  <= 0;
      last_word <= 32'h0;
    end else if (fifo_wr === 1'b1) begin
      word_cnt  <= word_cnt + 1;
      last_word <= fifo_data;
    end
  end
endmodule

// [dv/cpf_formatter_assertions.sv]
// Port-level checker of the pixel formatter.
`timescale 1ns/1ps
module cpf_formatter_assertions
  import cpf_pkg::*;
(
  input wire logic          ref_clk,
  input wire logic          sys_rst,
  input wire logic          hreadyout,
  input wire logic          hresp,
  input wire logic          pix_valid,
  input wire logic          line_start,
  input wire logic          field_start,
  input wire logic          field_even_in,
  input wire logic          line_reset_pulse,
  input wire cpf_vert_filter_taps_type vert_filter_taps_cfg,
  input wire logic          field_even,
  input wire logic          fifo_wr,
  input wire logic [31:0]   fifo_data
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  logic [6:0] hi_cnt;
  // A new line start restarts the count, since the pulse itself restarts then.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || line_start) begin
      hi_cnt <= 7'h00;
    end else if (line_reset_pulse) begin
      hi_cnt <= hi_cnt + 7'h01;
    end
  end
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  a_pulse_start: assert property (line_start |=> line_reset_pulse)
    else $error("line reset pulse did not start");
  a_pulse_width: assert property ($fell(line_reset_pulse) |->
                                  hi_cnt == CPF_HRST_NARROW || hi_cnt == CPF_HRST_STD)
    else $error("line reset pulse width wrong");
  a_data_hold: assert property ($changed(fifo_data) |-> fifo_wr)
    else $error("fifo data changed without a write");
  a_wr_cause: assert property (fifo_wr |-> $past(pix_valid, 2))
    else $error("fifo write without a pixel two cycles before");
  a_field_latch: assert property (field_start |=> field_even == $past(field_even_in))
    else $error("field flag not taken at field start");
  a_field_hold: assert property (!field_start |=> $stable(field_even))
    else $error("field flag changed inside a field");
  a_vert_filter_taps_range: assert property (vert_filter_taps_cfg.interp ?
                                  vert_filter_taps_cfg.taps inside {3'h0, [3'h2:3'h4]} :
                                  vert_filter_taps_cfg.taps inside {[3'h2:3'h5]})
    else $error("vertical filter setting out of range");
  c_word: cover property (fifo_wr);
  c_narrow: cover property ($fell(line_reset_pulse) && hi_cnt == 7'h20);
  c_even: cover property (field_start && field_even_in);
endmodule

bind cpf_formatter cpf_formatter_assertions chk_u (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .hreadyout(hreadyout), .hresp(hresp),
  .pix_valid(pix_valid), .line_start(line_start), .field_start(field_start),
  .field_even_in(field_even_in), .line_reset_pulse(line_reset_pulse),
  .vert_filter_taps_cfg(vert_filter_taps_cfg), .field_even(field_even), .fifo_wr(fifo_wr), .fifo_data(fifo_data)
);

// [dv/tb_top.sv]
// Self-checking bench of the pixel formatter: registers, filter, line pulse and pixel words.
`timescale 1ns/1ps
module tb_top
  import cpf_pkg::*;
;
  typedef struct packed {
    logic        w;
    logic [11:0] a;
    logic [7:0]  d;
    logic [7:0]  e;
  } cpf_reg_row_type;
  typedef struct packed {
    logic        fe;
    logic [7:0]  fmt;
    logic [7:0]  ctl;
    logic [7:0]  cap;
    logic [1:0]  np;
    logic [31:0] ex;
  } cpf_pix_row_type;
  localparam cpf_pix_type PX = 56'h00000012345600;
  localparam cpf_reg_row_type REGS [19] = '{
    '{0, 12'h06C, 8'h00, 8'h00}, '{0, 12'h0D4, 8'h00, 8'h00}, '{0, 12'h0D8, 8'h00, 8'h00},
    '{0, 12'h0C0, 8'h00, 8'h00}, '{1, 12'h06C, 8'h83, 8'h00}, '{0, 12'h06C, 8'h00, 8'h83},
    '{1, 12'h0D4, 8'hE7, 8'h00}, '{0, 12'h0D4, 8'h00, 8'hE7}, '{1, 12'h0D8, 8'hA5, 8'h00},
    '{0, 12'h0D8, 8'h00, 8'hA5}, '{1, 12'h0C0, 8'h0F, 8'h00}, '{0, 12'h0C0, 8'h00, 8'h0F},
    '{1, 12'h100, 8'hFF, 8'h00}, '{0, 12'h100, 8'h00, 8'h00}, '{1, 12'h07C, 8'h5A, 8'h00},
    '{0, 12'h06C, 8'h00, 8'h00}, '{0, 12'h0D4, 8'h00, 8'h00}, '{0, 12'h0D8, 8'h00, 8'h00},
    '{0, 12'h0C0, 8'h00, 8'h0F}};
  // Only documented format codes are programmed here.
  localparam cpf_pix_row_type PIX [10] = '{
    '{0, 8'h00, 8'h10, 8'h02, 2'd1, 32'h00123456}, '{0, 8'h00, 8'h18, 8'h02, 2'd1, 32'h34560012},
    '{0, 8'h00, 8'h12, 8'h02, 2'd1, 32'h12005634}, '{1, 8'h20, 8'h1A, 8'h01, 2'd1, 32'h00123456},
    '{1, 8'h20, 8'h15, 8'h01, 2'd1, 32'h56341200}, '{0, 8'h20, 8'h30, 8'h02, 2'd2, 32'h11AA11AA},
    '{0, 8'h20, 8'h10, 8'h02, 2'd2, 32'h11AB11AA}, '{0, 8'h00, 8'h50, 8'h02, 2'd1, 32'h00BFBFBF},
    '{0, 8'h00, 8'h00, 8'h02, 2'd1, 32'h00010A1C}, '{0, 8'h00, 8'h80, 8'h0A, 2'd1, 32'h00000209}};
  logic          ref_clk;
  logic          sys_rst;
  logic [31:0]   haddr;
  logic [1:0]    htrans;
  logic          hwrite;
  logic [31:0]   hwdata;
  logic          hreadyout;
  logic          hresp;
  logic [31:0]   hrdata;
  cpf_pix_type   pix_in;
  logic          pix_valid;
  logic          line_start;
  logic          field_start;
  logic          field_even_in;
  logic          pal_mode;
  logic          line_reset_pulse;
  cpf_vert_filter_taps_type vert_filter_taps_cfg;
  logic          field_even;
  logic          fifo_wr;
  logic [31:0]   fifo_data;
  int            word_cnt;
  logic [31:0]   last_word;
  int            fails = 0;
  int            checks = 0;

  // A short bar width keeps the colour bar case inside a few pixels.
  cpf_formatter #(.BAR_WIDTH(2)) dut_u (
    .ref_clk, .sys_rst, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .pix_in, .pix_valid, .line_start,
    .field_start, .field_even_in, .pal_mode, .line_reset_pulse, .vert_filter_taps_cfg,
    .field_even, .fifo_wr, .fifo_data
  );
  cpf_fifo_sink mdl_u (.ref_clk, .sys_rst, .fifo_wr, .fifo_data, .word_cnt, .last_word);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic final_report();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      fails++;
      final_report();
    end
  endtask

  // Entered just after a rising edge; ends on the edge that takes the data phase.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    htrans <= 2'h2;
    haddr  <= {20'h0, a};
    hwrite <= w;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask

  task automatic send(input logic fe, input logic [1:0] np);
    @(posedge ref_clk);
    field_start   <= 1'b1;
    field_even_in <= fe;
    line_start    <= 1'b1;
    @(posedge ref_clk);
    field_start <= 1'b0;
    line_start  <= 1'b0;
    for (int p = 0; p < np; p++) begin
      @(posedge ref_clk);
      pix_valid <= 1'b1;
      pix_in    <= PX;
    end
    @(posedge ref_clk);
    pix_valid <= 1'b0;
  endtask

  // Sends one line of pixels and compares the word that reaches the FIFO.
  task automatic word_case(input logic fe, input logic [1:0] np, input logic [31:0] ex);
    int n;
    int c0;
    c0 = word_cnt;
    send(fe, np);
    chk("field_even", {31'h0, fe}, {31'h0, field_even});
    n = 0;
    while (word_cnt == c0 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    if (word_cnt == c0) begin
      fails++;
      final_report();
    end
    chk("fifo word", ex, last_word);
  endtask

  initial begin
    logic [31:0] q;
    logic [3:0]  ev;
    int          n;
    int          c0;
    sys_rst = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    pix_in = '0;
    pix_valid = 1'b0;
    line_start = 1'b0;
    field_start = 1'b0;
    field_even_in = 1'b0;
    pal_mode = 1'b0;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    foreach (REGS[i]) begin
      bus(REGS[i].w, REGS[i].a, {24'h0, REGS[i].d}, q);
      if (!REGS[i].w) chk("register", {24'h0, REGS[i].e}, q);
    end
    bus(1'b0, CPF_OFS_SOFT_RESET_CMD, 32'h0, q);
    chk("reset location read", 32'h0, q);
    // No pixels flow while filter codes change, so the FIFO cannot overrun.
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, CPF_OFS_STREAM, {29'h0, i[2], 2'h0}, q);
      bus(1'b1, CPF_OFS_VTC, {30'h0, i[1:0]}, q);
      @(posedge ref_clk);
      if (i[2]) ev = {3'(i[1:0]) + 3'd2, 1'b0};
      else if (i[1:0] == 2'h0) ev = 4'h1;
      else ev = {3'(i[1:0]) + 3'd1, 1'b1};
      chk("vert_filter_taps_cfg", {28'h0, ev}, {28'h0, vert_filter_taps_cfg});
    end
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, CPF_OFS_VTC, k ? 32'h00000080 : 32'h00000000, q);
      @(posedge ref_clk);
      line_start <= 1'b1;
      @(posedge ref_clk);
      line_start <= 1'b0;
      // Sampled at the falling edge so every cycle of the pulse is counted once.
      n = 0;
      repeat (80) begin
        @(negedge ref_clk);
        if (line_reset_pulse === 1'b1) n++;
      end
      @(posedge ref_clk);
      chk("pulse width", k ? 32'h00000020 : 32'h00000040, n);
    end
    foreach (PIX[i]) begin
      bus(1'b1, CPF_OFS_FMT, {24'h0, PIX[i].fmt}, q);
      bus(1'b1, CPF_OFS_CTL, {24'h0, PIX[i].ctl}, q);
      bus(1'b1, CPF_OFS_STREAM, {24'h0, PIX[i].cap}, q);
      word_case(PIX[i].fe, PIX[i].np, PIX[i].ex);
    end
    // The standard pin picks the gamma table unless the serial port mode hands it to software.
    pal_mode <= 1'b1;
    bus(1'b1, CPF_OFS_CTL, 32'h00000000, q);
    word_case(1'b0, 2'd1, 32'h00010A1C);
    bus(1'b1, CPF_OFS_STREAM, 32'h00000002, q);
    word_case(1'b0, 2'd1, 32'h00000209);
    c0 = word_cnt;
    bus(1'b1, CPF_OFS_STREAM, 32'h02, q);
    send(1'b1, 2'd1);
    repeat (6) @(posedge ref_clk);
    chk("word count", c0, word_cnt);
    // Hardware reset in mid-run clears every register, the stream control included.
    bus(1'b1, CPF_OFS_FMT, 32'h00000055, q);
    sys_rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    chk("fifo_data", 32'h00000000, fifo_data);
    chk("field_even", 32'h00000000, {31'h0, field_even});
    chk("line_reset_pulse", 32'h00000000, {31'h0, line_reset_pulse});
    bus(1'b0, CPF_OFS_FMT, 32'h00000000, q);
    chk("format after reset", {24'h0, CPF_FMT_RST}, q);
    bus(1'b0, CPF_OFS_STREAM, 32'h00000000, q);
    chk("stream after reset", {24'h0, CPF_STREAM_RST}, q);
    final_report();
  end
endmodule
